// [brae_regs.svh]
`ifndef BRAE_REGS_SVH
`define BRAE_REGS_SVH
// Operation
// [RULE_01] Up, Down and Subsystem ports each carry active-low reset, analyse and error.
// [RULE_02] Reset and analyse flow downward; error flows upward.
// [RULE_03] Up reset/analyse inverted to processor, re-driven active low on Down port.
// [RULE_04] Down, Subsystem and processor errors combine into active-low Up error.
// [RULE_05] Software drives subsystem reset/analyse and reads subsystem error level.
// [RULE_06] Word-addressed registers: reset write 0, analyse write 4, error read 0.
// [RULE_07] Writing bit 0 one asserts the subsystem output; zero deasserts it.
// [RULE_08] Error register bit 0 reads one while subsystem chain signals error.
// [RULE_09] Up reset or analyse also forces matching subsystem output, whatever registers hold.
// [RULE_10] Chain analyse puts local processor and lower boards into analyse mode.
// [RULE_11] Straps high give 10 Mbit/s; link-0 strap low gives 5 Mbit/s on link 0.
// [RULE_12] Links-1-to-3 strap low changes links 1 to 3 the same way.
// [RULE_13] Range selector held low; high makes straps choose 10 or 20 Mbit/s.
// [RULE_14] Unconnected reset, analyse and error inputs count as deasserted.
// [RULE_15] Error read is live, unlatched; control bits clear while Up reset asserted.
`define BRAE_OFS_SUB_RESET 32'h0000_0000
`define BRAE_OFS_SUB_ANALYSE 32'h0000_0004
`define BRAE_OFS_SUB_ERROR 32'h0000_0000
`define BRAE_CTRL_BIT 0
`define BRAE_CTRL_RESET 1'b0
`define BRAE_SPEED_LOW 2'h0
`define BRAE_SPEED_MID 2'h1
`define BRAE_SPEED_HIGH 2'h2
`endif

// [brae_pkg.sv]
package brae_pkg;
   // link rate codes: 5, 10 or 20 Mbit/s
   typedef enum logic [1:0] {
      BRAE_RATE_5 = 2'b00,
      BRAE_RATE_10 = 2'b01,
      BRAE_RATE_20 = 2'b10
   } brae_rate_t;
endpackage

// [brae_sync.sv]
`timescale 1ns/100ps
// two-flop synchroniser for a bank of pin levels
module brae_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   // elaboration check: an empty bank cannot be served
   if (WIDTH < 1)
   begin : g_bad_width
      $error("brae_sync width must be positive");
   end

   // next values: first stage read only by second
   always_comb
   begin
      meta_nxt = din;
      sync_nxt = meta_r;
   end

   // two stages
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= INIT;
         dout <= INIT;
      end
      else
      begin
         meta_r <= meta_nxt;
         dout <= sync_nxt;
      end
   end
endmodule // brae_sync

// [brae_ctrl.sv]
`timescale 1ns/100ps
`include "brae_regs.svh"
// board chain control: reset/analyse down, error up, subsystem registers
module brae_ctrl (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // up port
   input wire logic UPSTREAM_RESET_IN_N,
   input wire logic UPSTREAM_INSPECT_IN_N,
   output logic UPSTREAM_FAULT_OUT_N,
   // down port
   output logic DOWN_RESET_OUT_N,
   output logic DOWN_INSPECT_OUT_N,
   input wire logic DOWNSTREAM_FAULT_IN_N,
   // subsystem port
   output logic SUB_RESET_OUT_N,
   output logic SUB_INSPECT_OUT_N,
   input wire logic SUBCHAIN_FAULT_IN_N,
   // local processor
   output logic CPU_RESET,
   output logic CPU_ANALYSE,
   input wire logic CPU_ERROR,
   // processor register access, word addressed
   input wire logic REG_SEL,
   input wire logic REG_WR,
   input wire logic [31:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // link speed straps
   input wire logic FIRST_LINK_SPEED_STRAP,
   input wire logic OTHER_LINKS_SPEED_STRAP,
   input wire logic LINK_RANGE_SEL,
   output brae_pkg::brae_rate_t LINK0_RATE,
   output brae_pkg::brae_rate_t LINK123_RATE
);
   import brae_pkg::*;

   logic [4:0] pins_s;
   logic up_rst;
   logic up_ana;
   logic down_err;
   logic sub_err;
   logic cpu_err;
   logic [2:0] straps_s;
   logic sub_rst_r;
   logic sub_rst_nxt;
   logic sub_ana_r;
   logic sub_ana_nxt;
   logic fault_r;
   logic fault_nxt;
   logic [31:0] rdata_nxt;
   brae_rate_t rate0_nxt;
   brae_rate_t rate123_nxt;
   logic wr_reset_hit;
   logic wr_analyse_hit;
   logic rd_error_hit;

   // chain and error pins synchronised; reset shows every line idle, so no false fault
   brae_sync #(.WIDTH(5), .INIT(5'h1f)) u_sync (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .din({UPSTREAM_RESET_IN_N, UPSTREAM_INSPECT_IN_N, DOWNSTREAM_FAULT_IN_N,
            SUBCHAIN_FAULT_IN_N, ~CPU_ERROR}),
      .dout(pins_s)
   );
   // straps synchronised; reset shows both straps high and the range select low
   brae_sync #(.WIDTH(3), .INIT(3'h6)) u_strap (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .din({FIRST_LINK_SPEED_STRAP, OTHER_LINKS_SPEED_STRAP, LINK_RANGE_SEL}),
      .dout(straps_s)
   );

   // active-high views of chain lines; a pulled-up open line reads as deasserted
   assign up_rst = ~pins_s[4];   // see [RULE_14]
   assign up_ana = ~pins_s[3];   // see [RULE_14]
   assign down_err = ~pins_s[2];   // see [RULE_14]
   assign sub_err = ~pins_s[1];
   assign cpu_err = ~pins_s[0];

   // register decode on the full word address; reads and writes share offset 0
   assign wr_reset_hit = REG_SEL && REG_WR && (REG_ADDR == `BRAE_OFS_SUB_RESET);   // see [RULE_06]
   assign wr_analyse_hit = REG_SEL && REG_WR && (REG_ADDR == `BRAE_OFS_SUB_ANALYSE);
   assign rd_error_hit = REG_SEL && !REG_WR && (REG_ADDR == `BRAE_OFS_SUB_ERROR);

   // next control bits: bit 0 of a write, cleared while the up reset is asserted
   always_comb
   begin
      sub_rst_nxt = sub_rst_r;
      sub_ana_nxt = sub_ana_r;
      if (wr_reset_hit)
      begin
         sub_rst_nxt = REG_WDATA[`BRAE_CTRL_BIT];   // see [RULE_07]
      end
      if (wr_analyse_hit)
      begin
         sub_ana_nxt = REG_WDATA[`BRAE_CTRL_BIT];   // see [RULE_07]
      end
      // up reset wins over a write in the same cycle
      if (up_rst)
      begin
         sub_rst_nxt = `BRAE_CTRL_RESET;   // see [RULE_15]
         sub_ana_nxt = `BRAE_CTRL_RESET;
      end
   end

   // control bit registers
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sub_rst_r <= `BRAE_CTRL_RESET;
         sub_ana_r <= `BRAE_CTRL_RESET;
      end
      else
      begin
         sub_rst_r <= sub_rst_nxt;
         sub_ana_r <= sub_ana_nxt;
      end
   end

   // next upward error and read data; the error read is live, never latched
   always_comb
   begin
      fault_nxt = down_err | sub_err | cpu_err;   // see [RULE_04]
      rdata_nxt = 32'h0000_0000;
      if (rd_error_hit)
      begin
         rdata_nxt[`BRAE_CTRL_BIT] = sub_err;   // see [RULE_08] see [RULE_15]
      end
   end

   // upward error and read data registers
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         fault_r <= 1'b0;
         REG_RDATA <= 32'h0000_0000;
      end
      else
      begin
         fault_r <= fault_nxt;
         REG_RDATA <= rdata_nxt;
      end
   end

   // next link rates: a strap high picks the faster step, range select doubles both steps
   always_comb
   begin
      rate0_nxt = BRAE_RATE_10;   // see [RULE_11]
      rate123_nxt = BRAE_RATE_10;
      if (!straps_s[0])
      begin
         // normal range: a strap pulled low halves the default rate
         rate0_nxt = straps_s[2] ? BRAE_RATE_10 : BRAE_RATE_5;   // see [RULE_11]
         rate123_nxt = straps_s[1] ? BRAE_RATE_10 : BRAE_RATE_5;   // see [RULE_12]
      end
      else
      begin
         // doubled range: the same straps choose between 10 and 20
         rate0_nxt = straps_s[2] ? BRAE_RATE_20 : BRAE_RATE_10;   // see [RULE_13]
         rate123_nxt = straps_s[1] ? BRAE_RATE_20 : BRAE_RATE_10;   // see [RULE_13]
      end
   end

   // link rate registers; default rate while in reset
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         LINK0_RATE <= BRAE_RATE_10;
         LINK123_RATE <= BRAE_RATE_10;
      end
      else
      begin
         LINK0_RATE <= rate0_nxt;
         LINK123_RATE <= rate123_nxt;
      end
   end

   // chain outputs: reset/analyse downward, error upward
   assign CPU_RESET = up_rst;                    // see [RULE_03] see [RULE_02]
   assign CPU_ANALYSE = up_ana;                  // see [RULE_10]
   assign DOWN_RESET_OUT_N = ~up_rst;            // see [RULE_03] see [RULE_01]
   assign DOWN_INSPECT_OUT_N = ~up_ana;          // see [RULE_10]
   assign SUB_RESET_OUT_N = ~(sub_rst_r | up_rst);   // see [RULE_09] see [RULE_05]
   assign SUB_INSPECT_OUT_N = ~(sub_ana_r | up_ana); // see [RULE_09]
   assign UPSTREAM_FAULT_OUT_N = ~fault_r;       // see [RULE_04]

   a_down_follow: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      DOWN_RESET_OUT_N == !CPU_RESET && DOWN_INSPECT_OUT_N == !CPU_ANALYSE)
      else $error("down port does not mirror processor reset/analyse"); // see [RULE_03]
   a_fault_up: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (down_err | sub_err | cpu_err) |=> !UPSTREAM_FAULT_OUT_N)
      else $error("error not passed upward"); // see [RULE_04]
   a_fault_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      !(down_err | sub_err | cpu_err) |=> UPSTREAM_FAULT_OUT_N)
      else $error("spurious upward error"); // see [RULE_04]
   a_reset_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (REG_SEL && REG_WR && REG_ADDR == 32'h0 && !up_rst) |=> sub_rst_r == $past(REG_WDATA[0]))
      else $error("subsystem reset write not taken"); // see [RULE_07]
   a_analyse_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (REG_SEL && REG_WR && REG_ADDR == 32'h4 && !up_rst) |=> sub_ana_r == $past(REG_WDATA[0]))
      else $error("subsystem analyse write not taken"); // see [RULE_06]
   a_error_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (REG_SEL && !REG_WR && REG_ADDR == 32'h0) |=> REG_RDATA[0] == $past(sub_err))
      else $error("error read wrong"); // see [RULE_08]
   a_up_forces: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      up_rst |-> !SUB_RESET_OUT_N)
      else $error("up reset not forced to subsystem"); // see [RULE_09]
   a_bits_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      up_rst |=> !sub_rst_r && !sub_ana_r)
      else $error("control bits not cleared by up reset"); // see [RULE_15]
   a_default_rate: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (straps_s == 3'b110) |=> LINK0_RATE == BRAE_RATE_10 && LINK123_RATE == BRAE_RATE_10)
      else $error("default link rate wrong"); // see [RULE_11]
   a_inspect_forces: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // see [RULE_09]
      up_ana |-> !SUB_INSPECT_OUT_N)
      else $error("up analyse not forced to subsystem");
   a_sub_release: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // see [RULE_05]
      (!up_rst && !sub_rst_r) |-> SUB_RESET_OUT_N)
      else $error("subsystem reset driven without cause");
   a_read_idle: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // see [RULE_06]
      !rd_error_hit |=> REG_RDATA == 32'h0000_0000)
      else $error("read data not zero outside an error read");
   a_fast_range: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // see [RULE_13]
      (straps_s == 3'b111) |=> LINK0_RATE == BRAE_RATE_20 && LINK123_RATE == BRAE_RATE_20)
      else $error("doubled link rate wrong");
   a_slow_links: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // see [RULE_12]
      (straps_s == 3'b000) |=> LINK0_RATE == BRAE_RATE_5 && LINK123_RATE == BRAE_RATE_5)
      else $error("halved link rate wrong");
endmodule // brae_ctrl

// [brae_chain_model.sv]
`timescale 1ns/100ps
// far side: master controller on the up port, chained boards below
module brae_chain_model (
   input wire logic clk,
   input wire logic conn,
   input wire logic [3:0] cmd,
   output logic up_rst_n = 1'b1,
   output logic up_insp_n = 1'b1,
   output logic dn_flt_n = 1'b1,
   output logic sub_flt_n = 1'b1
);
   // active-low levels change off the sampling edge; unplugged lines sit at the pull-up
   always @(negedge clk)
   begin
      {up_rst_n, up_insp_n, dn_flt_n, sub_flt_n} <= conn ? ~cmd : 4'hf;
   end
endmodule // brae_chain_model

// [brae_ctrl_tb.sv]
`timescale 1ns/100ps
// bench for the board chain control block
module brae_ctrl_tb;
   import brae_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, conn = 1'b0, sel = 1'b0, wr = 1'b0, cpu_err = 1'b0;
   logic s0 = 1'b1, s1 = 1'b1, rng = 1'b0, chk_req = 1'b0, rb = 1'b0, ab = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, v, seed = 32'h42;
   logic [31:0] q[$];
   logic up_rst_n, up_insp_n, dn_flt_n, sub_flt_n, flt_n, dr_n, di_n, sr_n, si_n, cr, ca;
   brae_rate_t r0, r1;
   int bad_count = 0, comparisons = 0;
   wire logic [3:0] ec = conn ? cmd : 4'h0; // effective levels: reset, inspect, down, sub
   always #12.5 clk = ~clk;
   brae_chain_model far (.clk(clk), .conn(conn), .cmd(cmd), .up_rst_n(up_rst_n),
      .up_insp_n(up_insp_n), .dn_flt_n(dn_flt_n), .sub_flt_n(sub_flt_n));
   brae_ctrl dut (.CLK_SYS(clk), .ARST_N(arst_n), .UPSTREAM_RESET_IN_N(up_rst_n),
      .UPSTREAM_INSPECT_IN_N(up_insp_n), .UPSTREAM_FAULT_OUT_N(flt_n),
      .DOWN_RESET_OUT_N(dr_n), .DOWN_INSPECT_OUT_N(di_n), .DOWNSTREAM_FAULT_IN_N(dn_flt_n),
      .SUB_RESET_OUT_N(sr_n), .SUB_INSPECT_OUT_N(si_n), .SUBCHAIN_FAULT_IN_N(sub_flt_n),
      .CPU_RESET(cr), .CPU_ANALYSE(ca), .CPU_ERROR(cpu_err), .REG_SEL(sel), .REG_WR(wr),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .FIRST_LINK_SPEED_STRAP(s0),
      .OTHER_LINKS_SPEED_STRAP(s1), .LINK_RANGE_SEL(rng), .LINK0_RATE(r0), .LINK123_RATE(r1));
   // xorshift source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // single compare point
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("compared %0d, mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one register cycle, entered at a falling edge, strobe dropped a cycle later
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      sel <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(negedge clk);
      sel <= 1'b0;
      wr <= 1'b0;
      @(negedge clk);
   endtask
   // note the expected pin picture, then ask the watcher to look
   task look;
      q.push_back({21'h0, ~(ec[1] | ec[0] | cpu_err), ~ec[3], ~ec[2], ~(rb | ec[3]),
         ~(ab | ec[2]), ec[3], ec[2], {1'b0, rng} + {1'b0, s0}, {1'b0, rng} + {1'b0, s1}});
      chk_req <= 1'b1;
      @(negedge clk);
      chk_req <= 1'b0;
   endtask
   logic take_pic, take_rd;
   logic [31:0] pic;
   // watcher: takes the oldest note whenever read data or a pin picture is due
   always @(posedge clk)
   begin
      take_pic = chk_req;
      take_rd = sel & ~wr;
      #1;
      pic = {21'h0, flt_n, dr_n, di_n, sr_n, si_n, cr, ca, r0, r1};
      if (take_rd) cmp(rdata, q.pop_front());
      if (take_pic) cmp(pic, q.pop_front());
   end
   initial
   begin
      #(25 * 3000);
      bad_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      wrap_up;
   end
   initial
   begin
      repeat (5) @(negedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      look;
      $display("idle test done");
      repeat (24)
      begin
         v = xs();
         {conn, cmd, cpu_err, s0, s1, rng} <= v[8:0];
         repeat (5) @(negedge clk);
         if (ec[3]) {rb, ab} = 2'b00;
         v = xs();
         bus(1'b1, 32'h0, v);
         if (!ec[3]) rb = v[0];
         v = xs();
         bus(1'b1, 32'h4, v);
         if (!ec[3]) ab = v[0];
         bus(1'b1, 32'h8, xs()); // unmapped place, no effect expected
         repeat (3) @(negedge clk);
         look;
         q.push_back({31'h0, ec[0]});
         bus(1'b0, 32'h0, 32'h0);
      end
      $display("random chain test done");
      // mid-run reset: control bits set beforehand must come back cleared
      {conn, cpu_err, s0, s1, rng} <= 5'h06;
      repeat (5) @(negedge clk);
      bus(1'b1, 32'h0, 32'h1);
      bus(1'b1, 32'h4, 32'h1);
      {rb, ab} = 2'b11;
      look;
      arst_n <= 1'b0;
      repeat (5) @(negedge clk);
      arst_n <= 1'b1;
      {rb, ab} = 2'b00;
      repeat (3) @(negedge clk);
      look;
      q.push_back({31'h0, ec[0]});
      bus(1'b0, 32'h0, 32'h0);
      $display("mid-run reset test done");
      wrap_up;
   end
endmodule // brae_ctrl_tb
